/* wrsc_pkg.sv */
// shared constants for the watchdog, recovery and skew control block
package wrsc_pkg;

	// register offsets (command codes)
	localparam logic [7:0] WRSC_OFF_WD_RESET_CTL = 8'h00;
	localparam logic [7:0] WRSC_OFF_SKEW_CTL = 8'h01;
	localparam logic [7:0] WRSC_OFF_REC_N = 8'h02;
	localparam logic [7:0] WRSC_OFF_REC_M = 8'h03;
	localparam logic [7:0] WRSC_OFF_WD_CFG = 8'h04;
	localparam logic [7:0] WRSC_OFF_STRAP_SEL = 8'h05;
	localparam logic [7:0] WRSC_OFF_SEL_LOW = 8'h06;

	// watchdog_reset_control fields
	localparam int WRSC_BIT_PCI_DRIVE_STRENGTH_SEL = 6;
	localparam int WRSC_BIT_RST_WD = 4;
	localparam int WRSC_BIT_RST_FC = 3;
	localparam int WRSC_BIT_TO_FLAG = 2;
	localparam int WRSC_BIT_WD_RUN = 1;
	localparam logic [7:0] WRSC_WD_CTL_WMASK = 8'h5A;

	// output_skew_control fields
	localparam int WRSC_CPU_SHIFT_LSB = 5;
	localparam int WRSC_PCI_SHIFT_LSB = 2;
	localparam int WRSC_AGP_SHIFT_LSB = 0;
	localparam logic [7:0] WRSC_SKEW_WMASK = 8'hEF;

	// recovery_divider_m fields
	localparam int WRSC_BIT_REC_SRC = 7;

	// watchdog config fields
	localparam int WRSC_BIT_STRAP_OVR = 6;
	localparam int WRSC_TO_VAL_LSB = 1;
	localparam int WRSC_BIT_SCALE = 0;
	localparam logic [7:0] WRSC_WD_CFG_WMASK = 8'h7F;

	// reset values
	localparam logic [7:0] WRSC_RST_REG = 8'h00;

	// programmable cpu frequency range of the synthesiser
	localparam int WRSC_CPU_FREQ_MIN_MHZ = 50;
	localparam int WRSC_CPU_FREQ_MAX_MHZ = 248;

	// timing
	localparam int WRSC_CLK_HZ = 20000000;
	localparam int WRSC_UNIT_SHORT_MS = 150;
	localparam int WRSC_UNIT_LONG_MS = 2500;
	localparam int WRSC_RST_PULSE_US = 1000;
	localparam int WRSC_UNIT_SHORT_CYC = (WRSC_CLK_HZ / 1000) * WRSC_UNIT_SHORT_MS;
	localparam int WRSC_UNIT_LONG_CYC = (WRSC_CLK_HZ / 1000) * WRSC_UNIT_LONG_MS;
	localparam int WRSC_RST_PULSE_CYC = (WRSC_CLK_HZ / 1000000) * WRSC_RST_PULSE_US;

	// bus address of this device, value arbitrary
	localparam logic [6:0] WRSC_SMB_DEV_ADDR = 7'h34;

	// byte roles on the serial bus
	localparam logic [1:0] WRSC_KIND_ADDR = 2'h0;
	localparam logic [1:0] WRSC_KIND_CMD = 2'h1;
	localparam logic [1:0] WRSC_KIND_DATA = 2'h2;

endpackage

/* wrsc_smbus_slave.sv */
// serial management bus slave: pin sampling, byte framing, register access
`timescale 1ns/1ps
`default_nettype none
module wrsc_smbus_slave
	import wrsc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = WRSC_SMB_DEV_ADDR
)(
	input wire logic clock,
	input wire logic resetn,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	output logic [7:0] reg_addr,
	output logic [7:0] wr_data,
	output logic wr_stb,
	input wire logic [7:0] rd_data
);

	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TACK} wrsc_smb_e;

	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic scl_f_q;
	logic sda_f_q;
	logic scl_new;
	logic sda_new;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	wrsc_smb_e st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] ptr_q, ptr_d;
	logic [1:0] kind_q, kind_d;
	logic rw_q, rw_d;
	logic oe_q, oe_d;
	logic wr_q, wr_d;

	// change counts once stages two and three agree
	always_comb
	begin
		scl_new = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
		sda_new = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
		scl_rise = scl_new & ~scl_f_q;
		scl_fall = ~scl_new & scl_f_q;
		start_c = scl_f_q & scl_new & sda_f_q & ~sda_new;
		stop_c = scl_f_q & scl_new & ~sda_f_q & sda_new;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end
		else
		begin
			scl_s_q <= {scl_s_q[1:0], smb_clk};
			sda_s_q <= {sda_s_q[1:0], smb_data_in};
			scl_f_q <= scl_new;
			sda_f_q <= sda_new;
		end
	end

	always_comb
	begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		kind_d = kind_q;
		rw_d = rw_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		if (start_c)
		begin
			st_d = S_RX;
			bit_d = 4'h0;
			kind_d = WRSC_KIND_ADDR;
			oe_d = 1'b0;
		end
		else if (stop_c)
		begin
			st_d = S_IDLE;
			oe_d = 1'b0;
		end
		else
		begin
			unique case (st_q)
				S_IDLE:
				begin
				end
				S_RX:
				begin
					if (scl_rise && bit_q != 4'h8)
					begin
						sh_d = {sh_q[6:0], sda_new};
						bit_d = bit_q + 4'h1;
					end
					else if (scl_fall && bit_q == 4'h8)
					begin
						st_d = S_ACK;
						oe_d = 1'b1;
						if (kind_q == WRSC_KIND_ADDR)
						begin
							rw_d = sh_q[0];
							if (sh_q[7:1] != DEV_ADDR)
							begin
								st_d = S_IDLE;
								oe_d = 1'b0;
							end
						end
						else if (kind_q == WRSC_KIND_CMD)
							ptr_d = sh_q;
						else
							wr_d = 1'b1;
					end
				end
				S_ACK:
				begin
					if (scl_fall)
					begin
						bit_d = 4'h0;
						if (kind_q == WRSC_KIND_ADDR && rw_q)
						begin
							sh_d = rd_data;
							oe_d = ~rd_data[7];
							bit_d = 4'h1;
							st_d = S_TX;
						end
						else
						begin
							oe_d = 1'b0;
							if (kind_q == WRSC_KIND_DATA)
								ptr_d = ptr_q + 8'h01;
							kind_d = (kind_q == WRSC_KIND_ADDR) ? WRSC_KIND_CMD : WRSC_KIND_DATA;
							st_d = S_RX;
						end
					end
				end
				S_TX:
				begin
					if (scl_fall)
					begin
						if (bit_q == 4'h8)
						begin
							oe_d = 1'b0;
							st_d = S_TACK;
						end
						else
						begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6];
							bit_d = bit_q + 4'h1;
						end
					end
				end
				S_TACK:
				begin
					if (scl_rise)
					begin
						if (sda_new)
							st_d = S_IDLE;
						else
						begin
							ptr_d = ptr_q + 8'h01;
							bit_d = 4'h9;
						end
					end
					else if (scl_fall && bit_q == 4'h9)
					begin
						sh_d = rd_data;
						oe_d = ~rd_data[7];
						bit_d = 4'h1;
						st_d = S_TX;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= S_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			kind_q <= WRSC_KIND_ADDR;
			rw_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			kind_q <= kind_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
		end
	end

	// open drain: the level driven is always low
	assign smb_data_out = 1'b0;
	assign smb_data_oe = oe_q;
	assign reg_addr = ptr_q;
	assign wr_data = sh_q;
	assign wr_stb = wr_q;

endmodule // wrsc_smbus_slave
`default_nettype wire

/* wrsc_ctl.sv */
// watchdog, reset pulse, recovery frequency and output skew control
`timescale 1ns/1ps
`default_nettype none
module wrsc_ctl
	import wrsc_pkg::*;
#(
	parameter int UNIT_SHORT_CYC = WRSC_UNIT_SHORT_CYC,
	parameter int UNIT_LONG_CYC = WRSC_UNIT_LONG_CYC,
	parameter int RST_PULSE_CYC = WRSC_RST_PULSE_CYC,
	parameter logic [6:0] DEV_ADDR = WRSC_SMB_DEV_ADDR
)(
	input wire logic clock,
	input wire logic resetn,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe,
	input wire logic [4:0] strap_freq_code,
	output logic reset_out_n,
	output logic pci_drive_strength_sel,
	output logic [2:0] cpu_clock_shift,
	output logic [1:0] pci_clock_shift,
	output logic [1:0] agp_clock_shift,
	output logic [4:0] freq_ratio_code,
	output logic recovery_active,
	output logic recovery_source_select,
	output logic [7:0] recovery_n_value,
	output logic [6:0] recovery_m_value,
	output logic freq_change
);

	localparam int PW = $clog2(UNIT_LONG_CYC + 1);
	localparam int RW = $clog2(RST_PULSE_CYC + 1);
	localparam logic [PW-1:0] SHORT_LAST = PW'(UNIT_SHORT_CYC - 1);
	localparam logic [PW-1:0] LONG_LAST = PW'(UNIT_LONG_CYC - 1);
	localparam logic [RW-1:0] RST_LEN = RW'(RST_PULSE_CYC);

	typedef enum logic [1:0] {WD_IDLE, WD_ARMED, WD_COUNT} wrsc_wd_e;

	logic [7:0] reg_addr;
	logic [7:0] wr_data;
	logic wr_stb;
	logic [7:0] rd_data;

	logic [7:0] ctl_q, ctl_d;
	logic [7:0] skew_q, skew_d;
	logic [7:0] rec_n_q, rec_n_d;
	logic [7:0] rec_m_q, rec_m_d;
	logic [7:0] wdcfg_q, wdcfg_d;
	logic [4:0] sel_q, sel_d;

	logic [4:0] strap_s0_q, strap_s1_q, strap_s2_q;
	logic [4:0] strap_lat_q, strap_lat_d;
	logic [2:0] strap_age_q, strap_age_d;

	wrsc_wd_e wd_q, wd_d;
	logic [5:0] cnt_q, cnt_d;
	logic [PW-1:0] pre_q, pre_d;
	logic timeout_c;
	logic nm_write_c;
	logic [5:0] reload_c;

	logic [RW-1:0] rst_cnt_q, rst_cnt_d;
	logic rst_n_q, rst_n_d;
	logic recov_q, recov_d;
	logic chg_q, chg_d;
	logic [4:0] ratio_q, ratio_d;

	function automatic logic hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
		hit = stb && (a == off);
	endfunction

	wrsc_smbus_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_smb (
		.clock(clock),
		.resetn(resetn),
		.smb_clk(smb_clk),
		.smb_data_in(smb_data_in),
		.smb_data_out(smb_data_out),
		.smb_data_oe(smb_data_oe),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.wr_stb(wr_stb),
		.rd_data(rd_data)
	);

	// register read-back; unmapped and reserved bits read zero
	always_comb
	begin
		unique case (reg_addr)
			WRSC_OFF_WD_RESET_CTL: rd_data = ctl_q & (WRSC_WD_CTL_WMASK | 8'h04);
			WRSC_OFF_SKEW_CTL: rd_data = skew_q & WRSC_SKEW_WMASK;
			WRSC_OFF_REC_N: rd_data = rec_n_q;
			WRSC_OFF_REC_M: rd_data = rec_m_q;
			WRSC_OFF_WD_CFG: rd_data = wdcfg_q & WRSC_WD_CFG_WMASK;
			WRSC_OFF_STRAP_SEL: rd_data = {strap_lat_q, 2'b00, sel_q[4]};
			WRSC_OFF_SEL_LOW: rd_data = {4'h0, sel_q[3:0]};
			default: rd_data = 8'h00;
		endcase
	end

	// register writes
	always_comb
	begin
		ctl_d = ctl_q;
		skew_d = skew_q;
		rec_n_d = rec_n_q;
		rec_m_d = rec_m_q;
		wdcfg_d = wdcfg_q;
		sel_d = sel_q;
		if (hit(wr_stb, reg_addr, WRSC_OFF_WD_RESET_CTL))
		begin
			ctl_d = (ctl_q & ~WRSC_WD_CTL_WMASK) | (wr_data & WRSC_WD_CTL_WMASK);
			if (wr_data[WRSC_BIT_TO_FLAG])
				ctl_d[WRSC_BIT_TO_FLAG] = 1'b0;
		end
		// a timeout in the clearing cycle still sets the flag
		if (timeout_c)
			ctl_d[WRSC_BIT_TO_FLAG] = 1'b1;
		if (hit(wr_stb, reg_addr, WRSC_OFF_SKEW_CTL))
			skew_d = wr_data & WRSC_SKEW_WMASK;
		if (hit(wr_stb, reg_addr, WRSC_OFF_REC_N))
			rec_n_d = wr_data;
		if (hit(wr_stb, reg_addr, WRSC_OFF_REC_M))
			rec_m_d = wr_data;
		if (hit(wr_stb, reg_addr, WRSC_OFF_WD_CFG))
			wdcfg_d = wr_data & WRSC_WD_CFG_WMASK;
		if (hit(wr_stb, reg_addr, WRSC_OFF_STRAP_SEL))
			sel_d[4] = wr_data[0];
		if (hit(wr_stb, reg_addr, WRSC_OFF_SEL_LOW))
			sel_d[3:0] = wr_data[3:0];
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			ctl_q <= WRSC_RST_REG;
			skew_q <= WRSC_RST_REG;
			rec_n_q <= WRSC_RST_REG;
			rec_m_q <= WRSC_RST_REG;
			wdcfg_q <= WRSC_RST_REG;
			sel_q <= 5'h00;
		end
		else
		begin
			ctl_q <= ctl_d;
			skew_q <= skew_d;
			rec_n_q <= rec_n_d;
			rec_m_q <= rec_m_d;
			wdcfg_q <= wdcfg_d;
			sel_q <= sel_d;
		end
	end

	// strap pins are caught once, after reset release
	always_comb
	begin
		strap_lat_d = strap_lat_q;
		strap_age_d = strap_age_q;
		// wait until stage three holds a pin sample, then latch once
		if (strap_age_q < 3'h3)
			strap_age_d = strap_age_q + 3'h1;
		else if (strap_age_q == 3'h3 && strap_s1_q == strap_s2_q)
		begin
			strap_lat_d = strap_s2_q;
			strap_age_d = 3'h4;
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			strap_s0_q <= 5'h00;
			strap_s1_q <= 5'h00;
			strap_s2_q <= 5'h00;
			strap_lat_q <= 5'h00;
			strap_age_q <= 3'h0;
		end
		else
		begin
			strap_s0_q <= strap_freq_code;
			strap_s1_q <= strap_s0_q;
			strap_s2_q <= strap_s1_q;
			strap_lat_q <= strap_lat_d;
			strap_age_q <= strap_age_d;
		end
	end

	// watchdog
	always_comb
	begin
		nm_write_c = hit(wr_stb, reg_addr, WRSC_OFF_REC_N) ||
			hit(wr_stb, reg_addr, WRSC_OFF_REC_M);
		reload_c = {1'b0, wdcfg_q[WRSC_TO_VAL_LSB +: 5]} + 6'h01;
		wd_d = wd_q;
		cnt_d = cnt_q;
		pre_d = pre_q;
		timeout_c = 1'b0;
		if (!ctl_q[WRSC_BIT_WD_RUN])
		begin
			wd_d = WD_IDLE;
			cnt_d = reload_c;
			pre_d = '0;
		end
		else
		begin
			unique case (wd_q)
				WD_IDLE: wd_d = WD_ARMED;
				WD_ARMED:
				begin
					cnt_d = reload_c;
					pre_d = '0;
					if (nm_write_c)
						wd_d = WD_COUNT;
				end
				WD_COUNT:
				begin
					if (nm_write_c)
					begin
						cnt_d = reload_c;
						pre_d = '0;
					end
					else if (pre_q == (wdcfg_q[WRSC_BIT_SCALE] ? LONG_LAST : SHORT_LAST))
					begin
						pre_d = '0;
						cnt_d = cnt_q - 6'h01;
						if (cnt_q == 6'h01)
						begin
							timeout_c = 1'b1;
							wd_d = WD_ARMED;
						end
					end
					else
						pre_d = pre_q + PW'(1);
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wd_q <= WD_IDLE;
			cnt_q <= 6'h00;
			pre_q <= '0;
		end
		else
		begin
			wd_q <= wd_d;
			cnt_q <= cnt_d;
			pre_q <= pre_d;
		end
	end

	// reset pulse, recovery switch and frequency selection
	always_comb
	begin
		rst_cnt_d = rst_cnt_q;
		recov_d = recov_q;
		chg_d = nm_write_c || timeout_c;
		if (timeout_c)
			recov_d = 1'b1;
		else if (hit(wr_stb, reg_addr, WRSC_OFF_WD_RESET_CTL) && wr_data[WRSC_BIT_TO_FLAG])
			recov_d = 1'b0;
		if ((timeout_c && ctl_q[WRSC_BIT_RST_WD]) ||
			(chg_d && ctl_q[WRSC_BIT_RST_FC]))
			rst_cnt_d = RST_LEN;
		else if (rst_cnt_q != '0)
			rst_cnt_d = rst_cnt_q - RW'(1);
		rst_n_d = (rst_cnt_d == '0);
		if (recov_d && !rec_m_q[WRSC_BIT_REC_SRC])
			ratio_d = strap_lat_q;
		else
			ratio_d = wdcfg_q[WRSC_BIT_STRAP_OVR] ? sel_q : strap_lat_q;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_cnt_q <= '0;
			rst_n_q <= 1'b1;
			recov_q <= 1'b0;
			chg_q <= 1'b0;
			ratio_q <= 5'h00;
		end
		else
		begin
			rst_cnt_q <= rst_cnt_d;
			rst_n_q <= rst_n_d;
			recov_q <= recov_d;
			chg_q <= chg_d;
			ratio_q <= ratio_d;
		end
	end

	assign reset_out_n = rst_n_q;
	assign pci_drive_strength_sel = ctl_q[WRSC_BIT_PCI_DRIVE_STRENGTH_SEL];
	assign cpu_clock_shift = skew_q[WRSC_CPU_SHIFT_LSB +: 3];
	assign pci_clock_shift = skew_q[WRSC_PCI_SHIFT_LSB +: 2];
	assign agp_clock_shift = skew_q[WRSC_AGP_SHIFT_LSB +: 2];
	assign freq_ratio_code = ratio_q;
	assign recovery_active = recov_q;
	assign recovery_source_select = rec_m_q[WRSC_BIT_REC_SRC];
	// divider words pass unchanged to the synthesiser covering 50 to 248 MHz
	assign recovery_n_value = rec_n_q;
	assign recovery_m_value = rec_m_q[6:0];
	assign freq_change = chg_q;

endmodule // wrsc_ctl
`default_nettype wire

/* wrsc_ctl_props.sv */
// concurrent checks on the control block's ports
`timescale 1ns/1ps
`default_nettype none
module wrsc_ctl_props
#(
	parameter int RST_PULSE_CYC = 5
)(
	input wire logic clock,
	input wire logic resetn,
	input wire logic smb_data_out,
	input wire logic smb_data_oe,
	input wire logic reset_out_n,
	input wire logic recovery_active,
	input wire logic recovery_source_select,
	input wire logic [7:0] recovery_n_value,
	input wire logic [6:0] recovery_m_value,
	input wire logic freq_change
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	int low_cnt;
	int since_fc;
	// low time of the reset pulse and age of the last change event
	always_ff @(posedge clock or negedge resetn)
		if (!resetn)
		begin
			low_cnt <= 0;
			since_fc <= 100;
		end
		else
		begin
			low_cnt <= reset_out_n ? 0 : low_cnt + 1;
			since_fc <= freq_change ? 0 : (since_fc < 100 ? since_fc + 1 : 100);
		end
	a_pulse_len: assert property ($rose(reset_out_n) |-> low_cnt >= RST_PULSE_CYC)
		else $error("reset pulse too short");
	a_pulse_cause: assert property ($fell(reset_out_n) |-> freq_change || since_fc < 4)
		else $error("reset pulse without change event");
	a_recov_switch: assert property ($rose(recovery_active) |-> ##[0:2] (freq_change || since_fc < 4))
		else $error("recovery without frequency switch");
	a_fc_single: assert property (freq_change |=> !freq_change)
		else $error("change event longer than one cycle");
	a_n_write_fc: assert property ($changed(recovery_n_value) |-> ##[0:3] freq_change)
		else $error("n update without change event");
	a_m_write_fc: assert property ($changed(recovery_m_value) |-> ##[0:3] freq_change)
		else $error("m update without change event");
	a_src_write_fc: assert property ($changed(recovery_source_select) |-> ##[0:3] freq_change)
		else $error("source update without change event");
	a_od_low: assert property (smb_data_out == 1'b0)
		else $error("data pin driven high");
	a_ack_stand: assert property ($rose(smb_data_oe) |=> smb_data_oe [*4])
		else $error("data low shorter than a bit");
	c_pulse: cover property ($fell(reset_out_n));
	c_recov: cover property ($rose(recovery_active));
	c_ack: cover property ($rose(smb_data_oe));
endmodule // wrsc_ctl_props
`default_nettype wire

/* wrsc_host.sv */
// serial bus host model driving the register pins
`timescale 1ns/1ps
`default_nettype none
module wrsc_host
	import wrsc_pkg::*;
(
	input wire logic clock,
	input wire logic smb_data_oe,
	input wire logic smb_data_out,
	output logic smb_clk,
	output logic sda
);
	logic low;
	int nacks;
	// open-drain wire with pull-up
	assign sda = !(low || (smb_data_oe && !smb_data_out));
	initial
	begin
		low = 1'b0;
		smb_clk = 1'b1;
		nacks = 0;
	end
	task automatic q(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic start();
		low = 1'b0;
		// let the slave drop its ack before clock rises for a repeated start
		q(6);
		smb_clk = 1'b1;
		q(2);
		low = 1'b1;
		q(2);
		smb_clk = 1'b0;
	endtask
	task automatic stop();
		q(4);
		low = 1'b1;
		q(2);
		smb_clk = 1'b1;
		q(2);
		low = 1'b0;
		q(4);
	endtask
	task automatic bitx(input logic b, output logic r);
		q(4);
		low = !b;
		q(2);
		smb_clk = 1'b1;
		q(2);
		r = sda;
		smb_clk = 1'b0;
	endtask
	task automatic tx(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		if (r)
			nacks++;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] off, d0, d1, input int n);
		start();
		tx({a, 1'b0});
		tx(off);
		tx(d0);
		if (n > 1)
			tx(d1);
		stop();
	endtask
	task automatic rd(input logic [7:0] off, output logic [7:0] d);
		logic r;
		start();
		tx({WRSC_SMB_DEV_ADDR, 1'b0});
		tx(off);
		start();
		tx({WRSC_SMB_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(1'b1, r);
		stop();
	endtask
endmodule // wrsc_host
`default_nettype wire

/* tb_wrsc_ctl.sv */
// testbench for the watchdog, recovery and skew control block
`timescale 1ns/1ps
`default_nettype none
module tb_wrsc_ctl
	import wrsc_pkg::*;
;
	localparam int US = 100;
	localparam int UL = 200;
	localparam int RP = 5;
	logic clock, resetn, smb_clk, sda, smb_data_out, smb_data_oe, reset_out_n;
	logic pci_drive_strength_sel, recovery_active, recovery_source_select, freq_change;
	logic [4:0] strap, freq_ratio_code;
	logic [2:0] cpu_clock_shift;
	logic [1:0] pci_clock_shift, agp_clock_shift;
	logic [7:0] recovery_n_value;
	logic [6:0] recovery_m_value;
	logic rec_p = 1'b0;
	logic rst_p = 1'b1;
	int fails, compares, cyc, t_fc, t_rise, n_pulse;
	wrsc_ctl #(.UNIT_SHORT_CYC(US), .UNIT_LONG_CYC(UL), .RST_PULSE_CYC(RP)) u_wrsc_ctl (
		.clock(clock), .resetn(resetn), .smb_clk(smb_clk), .smb_data_in(sda),
		.smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .strap_freq_code(strap),
		.reset_out_n(reset_out_n), .pci_drive_strength_sel(pci_drive_strength_sel),
		.cpu_clock_shift(cpu_clock_shift), .pci_clock_shift(pci_clock_shift),
		.agp_clock_shift(agp_clock_shift), .freq_ratio_code(freq_ratio_code),
		.recovery_active(recovery_active), .recovery_source_select(recovery_source_select),
		.recovery_n_value(recovery_n_value), .recovery_m_value(recovery_m_value),
		.freq_change(freq_change));
	wrsc_host u_host (.clock(clock), .smb_data_oe(smb_data_oe), .smb_data_out(smb_data_out),
		.smb_clk(smb_clk), .sda(sda));
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// event times in cycles, and pulse count
	always @(posedge clock)
	begin
		cyc++;
		if (recovery_active && !rec_p)
			t_rise = cyc;
		if (freq_change && !recovery_active)
			t_fc = cyc;
		if (!reset_out_n && rst_p)
			n_pulse++;
		rec_p = recovery_active;
		rst_p = reset_out_n;
	end
	task automatic wrap_up();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_n(input int got, exp, tol);
		compares++;
		if (got < exp - tol || got > exp + tol)
		begin
			fails++;
			$display("ERROR %0t count %0d exp %0d", $time, got, exp);
		end
	endtask
	task automatic w(input logic [7:0] off, d0, d1 = 8'h00, input int n = 1);
		u_host.wr(WRSC_SMB_DEV_ADDR, off, d0, d1, n);
	endtask
	task automatic rc(input logic [7:0] off, exp);
		logic [7:0] d;
		u_host.rd(off, d);
		chk(d, exp);
	endtask
	task automatic t_reset();
		chk({pci_drive_strength_sel, cpu_clock_shift, pci_clock_shift, agp_clock_shift}, 8'h00);
		for (int i = 0; i < 5; i++)
			rc(8'(i), 8'h00);
		rc(WRSC_OFF_STRAP_SEL, {strap, 3'h0});
	endtask
	task automatic t_refuse();
		int n0;
		n0 = u_host.nacks;
		u_host.wr(WRSC_SMB_DEV_ADDR ^ 7'h01, WRSC_OFF_SKEW_CTL, 8'hFF, 8'h00, 1);
		chk_n(u_host.nacks - n0, 3, 0);
		rc(WRSC_OFF_SKEW_CTL, 8'h00);
		w(8'h07, 8'hFF);
		rc(8'h07, 8'h00);
	endtask
	task automatic t_ctl();
		w(WRSC_OFF_WD_RESET_CTL, 8'hFF);
		rc(WRSC_OFF_WD_RESET_CTL, 8'h5A);
		chk(pci_drive_strength_sel, 8'h01);
		w(WRSC_OFF_WD_RESET_CTL, 8'h00);
		chk(pci_drive_strength_sel, 8'h00);
	endtask
	task automatic t_skew();
		logic [1:0] pc;
		logic [7:0] v;
		for (int i = 0; i < 8; i++)
		begin
			pc = (i % 3 == 2) ? 2'h3 : 2'(i % 3);
			v = {i[2:0], 1'b1, pc, i[1:0]};
			w(WRSC_OFF_SKEW_CTL, v);
			rc(WRSC_OFF_SKEW_CTL, v & WRSC_SKEW_WMASK);
			chk(cpu_clock_shift, i[2:0]);
			chk(pci_clock_shift, pc);
			chk(agp_clock_shift, i[1:0]);
		end
	endtask
	task automatic t_strap();
		w(WRSC_OFF_STRAP_SEL, 8'hFF);
		w(WRSC_OFF_SEL_LOW, 8'hFA);
		rc(WRSC_OFF_STRAP_SEL, {strap, 3'h1});
		rc(WRSC_OFF_SEL_LOW, 8'h0A);
		chk(freq_ratio_code, strap);
		w(WRSC_OFF_WD_CFG, 8'h40);
		chk(freq_ratio_code, 8'h1A);
	endtask
	task automatic t_fcrst();
		int p0;
		p0 = n_pulse;
		w(WRSC_OFF_WD_RESET_CTL, 8'h08);
		w(WRSC_OFF_REC_N, 8'h5A);
		chk_n(n_pulse - p0, 1, 0);
		repeat (300) @(negedge clock);
		chk(recovery_active, 8'h00);
		rc(WRSC_OFF_WD_RESET_CTL, 8'h08);
		w(WRSC_OFF_WD_RESET_CTL, 8'h00);
		w(WRSC_OFF_REC_N, 8'h00);
		chk_n(n_pulse - p0, 1, 0);
	endtask
	task automatic t_wd(input logic [7:0] ctl, cfg, m, input int cyc_exp, np);
		int p0;
		p0 = n_pulse;
		w(WRSC_OFF_WD_CFG, cfg);
		w(WRSC_OFF_WD_RESET_CTL, ctl);
		w(WRSC_OFF_REC_N, 8'hA5, m, 2);
		for (int k = 0; k < 600 && recovery_active !== 1'b1; k++)
			@(negedge clock);
		repeat (20) @(negedge clock);
		chk(recovery_active, 8'h01);
		chk_n(t_rise - t_fc, cyc_exp, 3);
		chk_n(n_pulse - p0, np, 0);
		chk({recovery_source_select, recovery_m_value}, m);
		chk(recovery_n_value, 8'hA5);
		chk(freq_ratio_code, m[7] ? 8'h1A : {3'h0, strap});
		rc(WRSC_OFF_WD_RESET_CTL, ctl | 8'h04);
		w(WRSC_OFF_WD_RESET_CTL, ctl);
		rc(WRSC_OFF_WD_RESET_CTL, ctl | 8'h04);
		w(WRSC_OFF_WD_RESET_CTL, ctl | 8'h04);
		chk(recovery_active, 8'h00);
		rc(WRSC_OFF_WD_RESET_CTL, ctl);
	endtask
	initial
	begin
		resetn = 1'b0;
		strap = 5'h13;
		repeat (2) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		t_reset();
		t_refuse();
		t_ctl();
		t_skew();
		t_strap();
		t_fcrst();
		t_wd(8'h12, 8'h44, 8'h22, 3 * US, 1);
		t_wd(8'h02, 8'h43, 8'h85, 2 * UL, 0);
		wrap_up();
	end
	initial
	begin
		repeat (60000) @(posedge clock);
		fails++;
		wrap_up();
	end
endmodule // tb_wrsc_ctl
bind wrsc_ctl wrsc_ctl_props #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_wrsc_ctl_props (
	.clock(clock), .resetn(resetn), .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe),
	.reset_out_n(reset_out_n), .recovery_active(recovery_active),
	.recovery_source_select(recovery_source_select), .recovery_n_value(recovery_n_value),
	.recovery_m_value(recovery_m_value), .freq_change(freq_change));
`default_nettype wire
